// ---- supply_trip_detector_defs.svh ----
/*
  Constants of the supply trip detector: register byte addresses, field positions,
  reset values and interrupt bit positions.
  Assumes it is included by bare name from the package and the design file.
*/
`ifndef SUPPLY_TRIP_DETECTOR_DEFS_SVH
`define SUPPLY_TRIP_DETECTOR_DEFS_SVH

// ----------------------------------------
// Register byte addresses
// ----------------------------------------
`define ADDR_CONTROL 16'h2920
`define ADDR_CONTROL_CLEAR 16'h2924
`define ADDR_CONTROL_SET 16'h2928
`define ADDR_CONTROL_INVERT 16'h292c
`define ADDR_IRQ_STATUS 16'h2930
`define ADDR_IRQ_MASK 16'h2934

// ----------------------------------------
// Control field positions
// ----------------------------------------
`define BIT_POWER_ENABLE 15
`define BIT_STOP_IN_IDLE 13
`define BIT_CROSSING_DIRECTION 11
`define BIT_BANDGAP_STABLE 10
`define BIT_REFERENCE_STABLE 9
`define BIT_DETECT_EVENT 8
`define TRIP_LEVEL_MSB 3
`define TRIP_LEVEL_LSB 0

// Bits that software may write; all others are read-only or read as zero
`define CONTROL_WRITE_MASK 32'h0000a80f
`define CONTROL_RESET 32'h00000000

// ----------------------------------------
// Trip level codes and interrupt status bits
// ----------------------------------------
`define TRIP_CODE_EXTERNAL 4'hf
`define TRIP_CODE_LOWEST_VALID 4'h5
`define IRQ_BIT_DETECT 0
`define IRQ_BIT_REF_LOST 1
`define IRQ_WIDTH 2
`define IRQ_RESET 2'h0

`endif

// ---- supply_trip_detector_pkg.sv ----
/*
  Types of the supply trip detector: the control register image and the bundle of
  signals sent to the analog comparator.
  Assumes the constants header is on the include path.
*/
`include "supply_trip_detector_defs.svh"

package supply_trip_detector_pkg;

  // Writable control fields as held in flip-flops
  typedef struct packed {
    logic power_enable;
    logic stop_in_idle;
    logic crossing_direction;
    logic [3:0] trip_level_code;
  } control_t;

  // Drive towards the analog comparator and reference
  typedef struct packed {
    logic enable;
    logic rising;
    logic external_sense;
    logic [3:0] level;
  } analog_ctrl_t;

  // Detector operating state
  typedef enum logic [1:0] {
    ST_OFF,
    ST_WAIT_REF,
    ST_ARMED,
    ST_HALTED
  } detect_state_t;

endpackage

// ---- supply_trip_detector.sv ----
/*
  Supply trip detector control: register port, control register with clear, set and
  toggle aliases, synchroniser for the analog flags, crossing detection, sticky
  interrupt status with mask, and the drive of the analog comparator.
  Assumes a single 10 MHz clock, analog flags that are asynchronous to it, and a
  register master that issues one-cycle strobes and never waits.
*/
// Design decision made here: strobed register access.
// Behaviour
// [R1] Flag set on crossing in chosen direction
// [R2] Enabled flag raises interrupt request output
// [R3] Bit 15 powers detector; off means no events
// [R4] Bit 13 halts detector during idle
// [R5] Bit 11 picks rising or falling crossing
// [R6] Bit 10 read-only band-gap stable flag
// [R7] Bit 9 reference stable gates interrupt flag
// [R8] Software avoids enabling interrupt before reference stable
// [R9] Bit 8 shows detection event active
// [R10] Code 1111 routes external input to comparator
// [R11] Bits 3..0 trip code sent to comparator
// [R12] Software never programs codes 0100 to 0000
// [R13] Unimplemented control bits read as zero
// [R14] Clear, set, toggle aliases at 0x4/0x8/0xC
// [R15] Synchronise analog flags, detect qualifying transition
`timescale 1ns/100ps
`include "supply_trip_detector_defs.svh"

module supply_trip_detector #(
  parameter int SYNC_STAGES = 2
) (
  input wire logic CLOCK,
  input wire logic RST,
  input wire logic [15:0] ADDR,
  input wire logic [31:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  output logic [31:0] RDATA,
  input wire logic IDLE_MODE,
  input wire logic TRIP_CROSSED,
  input wire logic BANDGAP_STABLE,
  input wire logic REFERENCE_STABLE,
  output logic ANALOG_ENABLE,
  output logic ANALOG_RISING,
  output logic EXTERNAL_SENSE_SELECT,
  output logic [3:0] ANALOG_LEVEL,
  output logic IRQ
);

  // ----------------------------------------
  // Local helpers
  // ----------------------------------------
  // Control register image as seen on a read
  function automatic logic [31:0] control_image(
    input supply_trip_detector_pkg::control_t c,
    input logic bg, input logic rs, input logic ev);
    logic [31:0] v;
    v = 32'h00000000;
    v[`BIT_POWER_ENABLE] = c.power_enable;
    v[`BIT_STOP_IN_IDLE] = c.stop_in_idle;
    v[`BIT_CROSSING_DIRECTION] = c.crossing_direction;
    v[`BIT_BANDGAP_STABLE] = bg;
    v[`BIT_REFERENCE_STABLE] = rs;
    v[`BIT_DETECT_EVENT] = ev;
    v[`TRIP_LEVEL_MSB:`TRIP_LEVEL_LSB] = c.trip_level_code;
    return v; // [R13]
  endfunction

  // Writable fields extracted from a 32-bit word
  function automatic supply_trip_detector_pkg::control_t control_fields(
    input logic [31:0] w);
    supply_trip_detector_pkg::control_t c;
    c.power_enable = w[`BIT_POWER_ENABLE];
    c.stop_in_idle = w[`BIT_STOP_IN_IDLE];
    c.crossing_direction = w[`BIT_CROSSING_DIRECTION];
    c.trip_level_code = w[`TRIP_LEVEL_MSB:`TRIP_LEVEL_LSB];
    return c;
  endfunction

  // ----------------------------------------
  // Declarations
  // ----------------------------------------
  supply_trip_detector_pkg::control_t ctrl_q;
  supply_trip_detector_pkg::control_t ctrl_d;
  supply_trip_detector_pkg::detect_state_t state_q;
  supply_trip_detector_pkg::detect_state_t state_d;
  supply_trip_detector_pkg::analog_ctrl_t analog_d;
  supply_trip_detector_pkg::analog_ctrl_t analog_q;
  logic [2:0] sync_q [SYNC_STAGES];
  logic crossed_s;
  logic bandgap_s;
  logic refstable_s;
  logic crossed_prev_q;
  logic refstable_prev_q;
  logic event_active_q;
  logic [`IRQ_WIDTH-1:0] irq_status_q;
  logic [`IRQ_WIDTH-1:0] irq_mask_q;
  logic [`IRQ_WIDTH-1:0] irq_set;
  logic detect_pulse;
  logic ref_lost_pulse;
  logic running;
  logic [31:0] ctrl_word;
  logic [31:0] wr_bits;
  logic [31:0] rdata_d;

  // ----------------------------------------
  // Synchroniser for the analog flags
  // ----------------------------------------
  // Only the last stage is looked at; earlier stages may be metastable
  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      sync_q[0] <= 3'h0;
    end else begin
      sync_q[0] <= {TRIP_CROSSED, BANDGAP_STABLE, REFERENCE_STABLE}; // [R15]
    end
  end

  genvar gi;
  generate
    for (gi = 1; gi < SYNC_STAGES; gi++) begin : g_sync
      always_ff @(posedge CLOCK or posedge RST) begin
        if (RST) begin
          sync_q[gi] <= 3'h0;
        end else begin
          sync_q[gi] <= sync_q[gi-1];
        end
      end
    end
  endgenerate

  assign crossed_s = sync_q[SYNC_STAGES-1][2];
  assign bandgap_s = sync_q[SYNC_STAGES-1][1];
  assign refstable_s = sync_q[SYNC_STAGES-1][0];

  // ----------------------------------------
  // Control register and its aliases
  // ----------------------------------------
  // Read-only flags are masked out of every write, so writes to them do nothing
  always_comb begin
    ctrl_word = control_image(ctrl_q, 1'b0, 1'b0, 1'b0);
    wr_bits = WDATA & `CONTROL_WRITE_MASK; // [R6]
    ctrl_d = ctrl_q;
    if (WR) begin
      case (ADDR)
        `ADDR_CONTROL: ctrl_d = control_fields(wr_bits);
        `ADDR_CONTROL_CLEAR: ctrl_d = control_fields(ctrl_word & ~wr_bits); // [R14]
        `ADDR_CONTROL_SET: ctrl_d = control_fields(ctrl_word | wr_bits); // [R14]
        `ADDR_CONTROL_INVERT: ctrl_d = control_fields(ctrl_word ^ wr_bits); // [R14]
        default: ctrl_d = ctrl_q;
      endcase
    end
  end

  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      ctrl_q <= control_fields(`CONTROL_RESET);
    end else begin
      ctrl_q <= ctrl_d;
    end
  end

  // ----------------------------------------
  // Detector state
  // ----------------------------------------
  // Off when disabled, halted in idle if asked, waits for a stable reference
  always_comb begin
    case (state_q)
      supply_trip_detector_pkg::ST_OFF: state_d = supply_trip_detector_pkg::ST_WAIT_REF;
      supply_trip_detector_pkg::ST_WAIT_REF:
        state_d = refstable_s ? supply_trip_detector_pkg::ST_ARMED
                              : supply_trip_detector_pkg::ST_WAIT_REF; // [R7]
      supply_trip_detector_pkg::ST_ARMED:
        state_d = refstable_s ? supply_trip_detector_pkg::ST_ARMED
                              : supply_trip_detector_pkg::ST_WAIT_REF; // [R7]
      supply_trip_detector_pkg::ST_HALTED: state_d = supply_trip_detector_pkg::ST_WAIT_REF;
      default: state_d = supply_trip_detector_pkg::ST_OFF;
    endcase
    if (!ctrl_q.power_enable) begin
      state_d = supply_trip_detector_pkg::ST_OFF; // [R3]
    end else if (ctrl_q.stop_in_idle && IDLE_MODE) begin
      state_d = supply_trip_detector_pkg::ST_HALTED; // [R4]
    end
  end

  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      state_q <= supply_trip_detector_pkg::ST_OFF;
    end else begin
      state_q <= state_d;
    end
  end

  assign running = (state_q == supply_trip_detector_pkg::ST_ARMED);

  // ----------------------------------------
  // Crossing detection
  // ----------------------------------------
  // The comparator flag already reflects direction; a rising edge of it is a crossing.
  // Edge history restarts whenever the detector is not armed, so a level already
  // high at arming counts as a fresh crossing.
  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      crossed_prev_q <= 1'b0;
      refstable_prev_q <= 1'b0;
    end else begin
      crossed_prev_q <= running & crossed_s; // [R15]
      refstable_prev_q <= refstable_s;
    end
  end

  assign detect_pulse = running & crossed_s & ~crossed_prev_q; // [R1]
  assign ref_lost_pulse = ctrl_q.power_enable & refstable_prev_q & ~refstable_s;

  // Event status follows the qualified comparator level
  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      event_active_q <= 1'b0;
    end else begin
      event_active_q <= running & crossed_s; // [R9]
    end
  end

  // ----------------------------------------
  // Interrupt status and mask
  // ----------------------------------------
  assign irq_set = {ref_lost_pulse, detect_pulse};

  // Read of status clears it; a new event in the same cycle still wins
  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      irq_status_q <= `IRQ_RESET;
    end else if (RD && ADDR == `ADDR_IRQ_STATUS) begin
      irq_status_q <= irq_set; // [R1]
    end else begin
      irq_status_q <= irq_status_q | irq_set; // [R1]
    end
  end

  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      irq_mask_q <= `IRQ_RESET;
    end else if (WR && ADDR == `ADDR_IRQ_MASK) begin
      irq_mask_q <= WDATA[`IRQ_WIDTH-1:0];
    end
  end

  // Registered so the output comes straight from a flip-flop; one cycle behind status
  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      IRQ <= 1'b0;
    end else begin
      IRQ <= |(irq_status_q & irq_mask_q); // [R2]
    end
  end

  // ----------------------------------------
  // Analog comparator drive
  // ----------------------------------------
  always_comb begin
    analog_d.enable = ctrl_q.power_enable &&
                      state_q != supply_trip_detector_pkg::ST_HALTED; // [R3] [R4]
    analog_d.rising = ctrl_q.crossing_direction; // [R5]
    analog_d.external_sense = (ctrl_q.trip_level_code == `TRIP_CODE_EXTERNAL); // [R10]
    analog_d.level = ctrl_q.trip_level_code; // [R11]
  end

  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      analog_q <= '0;
    end else begin
      analog_q <= analog_d;
    end
  end

  assign ANALOG_ENABLE = analog_q.enable;
  assign ANALOG_RISING = analog_q.rising;
  assign EXTERNAL_SENSE_SELECT = analog_q.external_sense;
  assign ANALOG_LEVEL = analog_q.level;

  // ----------------------------------------
  // Read port
  // ----------------------------------------
  // Unmapped addresses and aliases read as zero
  always_comb begin
    rdata_d = 32'h00000000;
    if (RD) begin
      case (ADDR)
        `ADDR_CONTROL: rdata_d = control_image(ctrl_q, bandgap_s & ctrl_q.power_enable,
                                               refstable_s & ctrl_q.power_enable,
                                               event_active_q); // [R6] [R9] [R13]
        `ADDR_IRQ_STATUS: rdata_d = {30'h00000000, irq_status_q};
        `ADDR_IRQ_MASK: rdata_d = {30'h00000000, irq_mask_q};
        default: rdata_d = 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      RDATA <= 32'h00000000;
    end else begin
      RDATA <= rdata_d;
    end
  end

endmodule

// ---- supply_trip_detector_monitor.sv ----
/*
  Concurrent checks on the ports of the supply trip detector.
  Assumes one clock, an active-high asynchronous reset and the constants header.
*/
`timescale 1ns/100ps
`include "supply_trip_detector_defs.svh"
module supply_trip_detector_monitor (
  input wire logic CLOCK,
  input wire logic RST,
  input wire logic [15:0] ADDR,
  input wire logic [31:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  input wire logic [31:0] RDATA,
  input wire logic IDLE_MODE,
  input wire logic TRIP_CROSSED,
  input wire logic BANDGAP_STABLE,
  input wire logic REFERENCE_STABLE,
  input wire logic ANALOG_ENABLE,
  input wire logic ANALOG_RISING,
  input wire logic EXTERNAL_SENSE_SELECT,
  input wire logic [3:0] ANALOG_LEVEL,
  input wire logic IRQ
);
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (RST);
  // Control write taken, and the cycle in which a control read answers
  sequence ctrl_wr;
    WR && ADDR == `ADDR_CONTROL;
  endsequence
  sequence ctrl_answer;
    $past(RD) && $past(ADDR) == `ADDR_CONTROL;
  endsequence
  chk_reserved_zero: assert property (ctrl_answer |-> RDATA[31:16] == 16'h0 && !RDATA[14] &&
    !RDATA[12] && RDATA[7:4] == 4'h0) else $error("reserved control bits not zero");
  chk_flags_off: assert property ((ctrl_answer ##0 !RDATA[15]) |-> RDATA[10:8] == 3'h0)
    else $error("status flags set while detector off");
  chk_level_copy: assert property (ctrl_wr |-> ##2 ANALOG_LEVEL == $past(WDATA[3:0], 2))
    else $error("trip code not forwarded");
  chk_dir_copy: assert property (ctrl_wr |-> ##2 ANALOG_RISING == $past(WDATA[11], 2))
    else $error("direction not forwarded");
  chk_off_write: assert property ((ctrl_wr ##0 !WDATA[15]) |-> ##2 !ANALOG_ENABLE)
    else $error("comparator powered while off");
  chk_idle_halt: assert property ((ctrl_wr ##0 WDATA[13] ##1 (IDLE_MODE && !WR) [*2])
    |-> ##1 !ANALOG_ENABLE) else $error("comparator runs in idle");
  chk_mask_zero: assert property (WR && ADDR == `ADDR_IRQ_MASK && WDATA[1:0] == 2'h0
    |-> ##2 !IRQ) else $error("masked interrupt raised");
  chk_ext_select: assert property (EXTERNAL_SENSE_SELECT ==
    (ANALOG_LEVEL == `TRIP_CODE_EXTERNAL)) else $error("external sense select wrong");
endmodule

// ---- analog_partner.sv ----
/*
  Behavioural comparator and reference that face the supply trip detector.
  Assumes the detector's analog drive and the same clock and reset.
*/
`timescale 1ns/100ps
module analog_partner (
  input wire logic clk,
  input wire logic rst,
  input wire logic en,
  input wire logic rising,
  input wire logic ext,
  input wire logic [3:0] lvl,
  input wire logic [4:0] volt,
  input wire logic ref_ok,
  output logic crossed,
  output logic bg_ok,
  output logic rs_ok
);
  logic [2:0] warm_q;
  logic [4:0] trip;
  // Warm-up count; stability is lost at once when power is removed
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      warm_q <= 3'h0;
    end else if (!en) begin
      warm_q <= 3'h0;
    end else if (warm_q != 3'h7) begin
      warm_q <= warm_q + 3'h1;
    end
  end
  assign bg_ok = warm_q >= 3'h3;
  assign rs_ok = ref_ok && warm_q >= 3'h5;
  // Lower codes trip higher; volt stands for the external input when ext is set
  assign trip = 5'h10 - {1'b0, lvl};
  assign crossed = en && (rising ? volt >= trip : volt <= trip);
endmodule

// ---- tb_supply_trip_detector.sv ----
/*
  Self-checking bench of the supply trip detector with the behavioural partner.
  Assumes the design, its package, the header and the monitor are compiled first.
*/
`timescale 1ns/100ps
`include "supply_trip_detector_defs.svh"
module tb_supply_trip_detector;
  logic CLOCK = 1'b0;
  logic RST = 1'b1;
  logic [15:0] ADDR = 16'h0;
  logic [31:0] WDATA = 32'h0, RDATA, rv;
  logic WR = 1'b0, RD = 1'b0, IDLE_MODE = 1'b0, ref_ok = 1'b1;
  logic [4:0] volt = 5'h0;
  logic TRIP_CROSSED, BANDGAP_STABLE, REFERENCE_STABLE;
  logic ANALOG_ENABLE, ANALOG_RISING, EXTERNAL_SENSE_SELECT, IRQ;
  logic [3:0] ANALOG_LEVEL;
  int fails = 0, check_count = 0;
  always #50 CLOCK = ~CLOCK;
  supply_trip_detector uut (.CLOCK(CLOCK), .RST(RST), .ADDR(ADDR), .WDATA(WDATA), .WR(WR),
    .RD(RD), .RDATA(RDATA), .IDLE_MODE(IDLE_MODE), .TRIP_CROSSED(TRIP_CROSSED),
    .BANDGAP_STABLE(BANDGAP_STABLE), .REFERENCE_STABLE(REFERENCE_STABLE),
    .ANALOG_ENABLE(ANALOG_ENABLE), .ANALOG_RISING(ANALOG_RISING),
    .EXTERNAL_SENSE_SELECT(EXTERNAL_SENSE_SELECT), .ANALOG_LEVEL(ANALOG_LEVEL), .IRQ(IRQ));
  analog_partner far (.clk(CLOCK), .rst(RST), .en(ANALOG_ENABLE), .rising(ANALOG_RISING),
    .ext(EXTERNAL_SENSE_SELECT), .lvl(ANALOG_LEVEL), .volt(volt), .ref_ok(ref_ok),
    .crossed(TRIP_CROSSED), .bg_ok(BANDGAP_STABLE), .rs_ok(REFERENCE_STABLE));
  // ----------------------------------------
  // Bus and check helpers
  // ----------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      fails++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  task automatic wr(input logic [15:0] a, input logic [31:0] d);
    @(posedge CLOCK);
    ADDR <= a;
    WDATA <= d;
    WR <= 1'b1;
    @(posedge CLOCK);
    WR <= 1'b0;
  endtask
  // Read data stand only in the cycle after the strobe
  task automatic rd(input logic [15:0] a);
    @(posedge CLOCK);
    ADDR <= a;
    RD <= 1'b1;
    @(posedge CLOCK);
    RD <= 1'b0;
    #1 rv = RDATA;
  endtask
  // Bounded wait for the interrupt level; running out ends the run
  task automatic wait_irq(input logic e);
    for (int i = 0; i < 40 && IRQ !== e; i++) @(negedge CLOCK);
    chk({31'h0, IRQ}, {31'h0, e});
    if (IRQ !== e) report_and_stop;
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_regs;
    rd(`ADDR_CONTROL);
    chk(rv, `CONTROL_RESET);
    wr(`ADDR_CONTROL, 32'hffffffff);
    repeat (10) @(negedge CLOCK);
    rd(`ADDR_CONTROL);
    chk(rv, 32'h0000ae0f);
    wr(`ADDR_CONTROL_CLEAR, 32'h00008000);
    wr(`ADDR_CONTROL_SET, 32'h00000400);
    rd(`ADDR_CONTROL);
    chk(rv, 32'h0000280f);
    wr(`ADDR_CONTROL_INVERT, 32'h0000280a);
    wr(16'h2940, 32'hffffffff);
    rd(16'h2940);
    chk(rv, 32'h0);
    rd(`ADDR_CONTROL);
    chk(rv, 32'h00000005);
    $display("test regs done");
  endtask
  task automatic t_event;
    volt <= 5'h14;
    wr(`ADDR_CONTROL, 32'h00008005);
    repeat (10) @(negedge CLOCK);
    // Interrupt unmasked only once the reference has settled
    wr(`ADDR_IRQ_MASK, 32'h1);
    rd(`ADDR_IRQ_STATUS);
    volt <= 5'h05;
    wait_irq(1'b1);
    rd(`ADDR_CONTROL);
    chk(rv, 32'h00008705);
    wr(`ADDR_IRQ_MASK, 32'h0);
    repeat (3) @(negedge CLOCK);
    chk({31'h0, IRQ}, 32'h0);
    wr(`ADDR_IRQ_MASK, 32'h1);
    wait_irq(1'b1);
    rd(`ADDR_IRQ_STATUS);
    chk(rv & 32'h1, 32'h1);
    wait_irq(1'b0);
    volt <= 5'h14;
    wr(`ADDR_CONTROL, 32'h00008805);
    wait_irq(1'b1);
    rd(`ADDR_IRQ_STATUS);
    wait_irq(1'b0);
    $display("test event done");
  endtask
  // Detector off, halted in idle, and reference unstable: no event
  task automatic t_block;
    wr(`ADDR_CONTROL, 32'h00000805);
    repeat (10) @(negedge CLOCK);
    rd(`ADDR_IRQ_STATUS);
    chk(rv & 32'h1, 32'h0);
    @(posedge CLOCK);
    IDLE_MODE <= 1'b1;
    wr(`ADDR_CONTROL, 32'h0000a805);
    repeat (10) @(negedge CLOCK);
    rd(`ADDR_IRQ_STATUS);
    chk(rv & 32'h1, 32'h0);
    @(posedge CLOCK);
    IDLE_MODE <= 1'b0;
    wait_irq(1'b1);
    rd(`ADDR_IRQ_STATUS);
    ref_ok <= 1'b0;
    wr(`ADDR_CONTROL, 32'h00000805);
    wr(`ADDR_CONTROL, 32'h00008805);
    repeat (10) @(negedge CLOCK);
    rd(`ADDR_IRQ_STATUS);
    chk(rv & 32'h1, 32'h0);
    ref_ok <= 1'b1;
    $display("test block done");
  endtask
  task automatic t_levels;
    for (int c = 5; c < 16; c++) begin
      wr(`ADDR_CONTROL, {28'h0, c[3:0]});
      repeat (2) @(negedge CLOCK);
      chk({28'h0, ANALOG_LEVEL}, {28'h0, c[3:0]});
      chk({31'h0, EXTERNAL_SENSE_SELECT}, {31'h0, c == 15});
    end
    $display("test levels done");
  endtask
  initial begin
    repeat (16) @(posedge CLOCK);
    RST <= 1'b0;
    t_regs;
    t_event;
    t_block;
    t_levels;
    report_and_stop;
  end
endmodule
bind supply_trip_detector supply_trip_detector_monitor mon (.CLOCK(CLOCK), .RST(RST),
  .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA), .IDLE_MODE(IDLE_MODE),
  .TRIP_CROSSED(TRIP_CROSSED), .BANDGAP_STABLE(BANDGAP_STABLE),
  .REFERENCE_STABLE(REFERENCE_STABLE), .ANALOG_ENABLE(ANALOG_ENABLE),
  .ANALOG_RISING(ANALOG_RISING), .EXTERNAL_SENSE_SELECT(EXTERNAL_SENSE_SELECT),
  .ANALOG_LEVEL(ANALOG_LEVEL), .IRQ(IRQ));
